// *** cfgprog_pkg.sv ***
// Shared constants and types of the serial configuration programmer.
// Assumes one basic clock period per mclk cycle at 10 MHz.
package cfgprog_pkg;

    typedef logic [13:0] word_t;
    typedef logic [5:0] lim_t;
    typedef logic [11:0] tick_t;

    typedef enum logic [6:0]
    {
        ST_IDLE  = 7'h01,
        ST_DELAY = 7'h02,
        ST_SYNC  = 7'h04,
        ST_GAP   = 7'h08,
        ST_WIN   = 7'h10,
        ST_REST  = 7'h20,
        ST_EQ    = 7'h40
    } prog_state_e;

    localparam int unsigned WORD_BITS = 14;
    localparam logic [3:0] LAST_BIT = 4'hd;
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Reset contents of the configuration registers and the lowest valid limit.
    localparam word_t CFG_WORD_DEFAULT = 14'h0000;
    localparam lim_t LIM_DEFAULT = 6'h18;
    localparam lim_t LIM_LOWEST_VALID = 6'h0c;

    // Field layout of the received word.
    localparam int unsigned SEL_MSB = 13;
    localparam int unsigned SEL_LSB = 12;
    localparam logic [1:0] SEL_LIMIT = 2'h3;
    localparam int unsigned RANGE_MSB = 3;
    localparam int unsigned RANGE_LSB = 2;
    localparam int unsigned OFF_BIT = 0;

    // Start pulse classes, in basic clock periods.
    localparam logic [12:0] START_SHORT_MAX = 13'h05ff;
    localparam int unsigned START_LONG_MIN_DEFAULT = 5632;
    localparam int unsigned START_MIN_NS = 1000;
    localparam logic [12:0] START_MIN_CYC =
        13'((START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Marker half period and reset hold, in cycles (parameters of the top).
    localparam int unsigned MARKER_HALF_DEFAULT = 20000;
    localparam int unsigned RESET_HOLD_DEFAULT = 10000;

    // Transfer timing.
    localparam int unsigned PROG_DELAY_NS = 200000;
    localparam int unsigned SYNC_PULSE_NS = 50000;
    localparam int unsigned WIN_DELAY_NS = 50000;
    localparam int unsigned WIN_LEN_NS = 200000;
    localparam int unsigned BIT_FRAME_NS = 400000;
    localparam int unsigned ACK_PULSE_NS = 50000;
    localparam int unsigned EQ_WIN_NS = 200000;
    localparam tick_t PROG_DELAY_CYC = 12'((PROG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t SYNC_PULSE_CYC = 12'((SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t WIN_DELAY_CYC = 12'((WIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t WIN_LEN_CYC = 12'((WIN_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t BIT_FRAME_CYC = 12'((BIT_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t REST_CYC = BIT_FRAME_CYC - SYNC_PULSE_CYC - WIN_DELAY_CYC - WIN_LEN_CYC;
    localparam tick_t ACK_PULSE_CYC = 12'((ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam tick_t EQ_WIN_CYC = 12'((EQ_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : cfgprog_pkg

// *** input_sync.sv ***
// Two-flop synchroniser for asynchronous inputs.
// Assumes inputs come from pins outside the mclk domain.
`timescale 1ns/1ps
module input_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_level,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    stage_reg[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end
                else if (clk_en)
                begin
                    stage_reg[i] <= async_in[i];
                    sync_out[i] <= stage_reg[i];
                end
            end
        end
    endgenerate

endmodule : input_sync

// *** por_gen.sv ***
// Power-on and brown-out reset generator.
// Assumes supply_ok_s is already synchronised to mclk.
`timescale 1ns/1ps
module por_gen #(
    parameter int unsigned HOLD = 10000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic supply_ok_s,
    output logic por_active
);

    logic [15:0] hold_reg;

    // Reset holds while supply is low and for HOLD cycles after it recovers.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_reg <= 16'h0000;
            por_active <= 1'b1;
        end
        else if (clk_en)
        begin
            if (!supply_ok_s)
            begin
                hold_reg <= 16'h0000;
                por_active <= 1'b1; // [RQ2]
            end
            else if (hold_reg == 16'(HOLD - 1))
            begin
                por_active <= 1'b0; // [RQ3]
            end
            else
            begin
                hold_reg <= hold_reg + 16'h0001;
            end
        end
    end

    property p_por_on_low_supply;
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && !supply_ok_s) |=> por_active;
    endproperty
    a_por_on_low_supply: assert property (p_por_on_low_supply) // [RQ2]
        else $error("Reset not raised on low supply.");

    property p_por_min_hold;
        @(posedge mclk) disable iff (!rst_n)
        $fell(por_active) |-> $past(hold_reg) == 16'(HOLD - 1);
    endproperty
    a_por_min_hold: assert property (p_por_min_hold) // [RQ3]
        else $error("Reset released before hold period.");

endmodule : por_gen

// *** config_word_serial_programmer.sv ***
// Serial loader of the configuration registers over one open-drain data line.
// Assumes data_in and supply_ok are asynchronous pins; the wire level is
// resolved outside from data_oe (drive low while high).
//
// Function
// RQ1 - Limit field six bits, below 12 invalid, default 24.
// RQ2 - Low supply raises reset and loads defaults.
// RQ3 - Reset at power-up, held minimum period.
// RQ4 - After reset drive square-wave marker on line.
// RQ5 - Marker frequency below any data frequency.
// RQ6 - Host low pulse starts transfer; device then masters.
// RQ7 - After delay, fourteen timed synchronization pulses.
// RQ8 - After each pulse, delayed window samples line.
// RQ9 - Low in window writes zero, released writes one.
// RQ10 - Capture all fourteen bits in sequence.
// RQ11 - Equivalence window acknowledges identical word.
// RQ12 - Host programs twice to check acknowledge.
// RQ13 - Accept transfers in sleep or active state.
// RQ14 - Disable receive path during a transfer.
// RQ15 - Bit one set makes start an off command.
// RQ16 - Short start pulse ignored while marker shows.
// RQ17 - Long start pulse always starts, cancels marker.
// RQ18 - Host avoids start pulses between the two ranges.
`timescale 1ns/1ps
module config_word_serial_programmer #(
    parameter int unsigned START_LONG_MIN = cfgprog_pkg::START_LONG_MIN_DEFAULT,
    parameter int unsigned MARKER_HALF = cfgprog_pkg::MARKER_HALF_DEFAULT,
    parameter int unsigned RESET_HOLD = cfgprog_pkg::RESET_HOLD_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic supply_ok,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    output cfgprog_pkg::word_t config_word,
    output cfgprog_pkg::lim_t upper_bit_check_limit,
    output logic [8:0] limit_ticks,
    output logic rx_disable,
    output logic off_cmd,
    output logic reset_marker,
    output logic por_active
);
    import cfgprog_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and power-on reset.

    logic [1:0] sync_q;
    logic data_s;
    logic supply_s;
    logic por_q;

    input_sync #(.WIDTH(2)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in({supply_ok, data_in}),
        .reset_level(2'h3),
        .sync_out(sync_q)
    );

    assign data_s = sync_q[0];
    assign supply_s = sync_q[1];

    por_gen #(.HOLD(RESET_HOLD)) u_por (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .supply_ok_s(supply_s),
        .por_active(por_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Start pulse measurement.

    prog_state_e state_reg;
    tick_t timer_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] oe_hist_reg;
    logic [12:0] low_cnt_reg;
    logic own_drive;
    logic foreign_low;
    logic released;
    logic start_short;
    logic start_long;
    logic go;

    // Our own drive reaches data_s two cycles late, so it is masked that long.
    assign own_drive = data_oe | oe_hist_reg[0] | oe_hist_reg[1];
    assign foreign_low = !data_s && !own_drive;
    assign released = data_s && !own_drive;
    assign start_short = released && low_cnt_reg > START_MIN_CYC &&
                         low_cnt_reg < START_SHORT_MAX;
    assign start_long = released && low_cnt_reg > 13'(START_LONG_MIN);
    assign go = state_reg == ST_IDLE && !por_q &&
                (start_long || (start_short && !reset_marker)); // [RQ6] [RQ16] [RQ17]

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_hist_reg <= 2'h0;
            low_cnt_reg <= 13'h0000;
        end
        else if (clk_en)
        begin
            oe_hist_reg <= {oe_hist_reg[0], data_oe};
            if (state_reg != ST_IDLE || released)
            begin
                low_cnt_reg <= 13'h0000;
            end
            else if (foreign_low && low_cnt_reg != 13'h1fff)
            begin
                low_cnt_reg <= low_cnt_reg + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer; it runs the same from sleep or active state.

    word_t rx_word_reg;
    logic zero_seen_reg;
    logic eq_reg;
    logic commit;
    logic rx_bit;
    logic lim_target;
    logic word_equal;

    assign commit = state_reg == ST_REST && timer_reg == REST_CYC - 12'h001 &&
                    bit_cnt_reg == LAST_BIT;
    assign rx_bit = !(zero_seen_reg || foreign_low); // [RQ9]
    assign lim_target = rx_word_reg[SEL_MSB:SEL_LSB] == SEL_LIMIT;
    assign word_equal = lim_target ? rx_word_reg[5:0] == upper_bit_check_limit :
                        rx_word_reg == config_word;

    always_ff @(posedge mclk or negedge rst_n) // [RQ13]
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= 12'h000;
            bit_cnt_reg <= 4'h0;
            zero_seen_reg <= 1'b0;
            rx_word_reg <= CFG_WORD_DEFAULT;
            eq_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            timer_reg <= timer_reg + 12'h001;
            case (state_reg)
                ST_IDLE:
                begin
                    timer_reg <= 12'h000;
                    bit_cnt_reg <= 4'h0;
                    if (go)
                    begin
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY:
                begin
                    if (timer_reg == PROG_DELAY_CYC - 12'h001)
                    begin
                        state_reg <= ST_SYNC; // [RQ7]
                        timer_reg <= 12'h000;
                    end
                end
                ST_SYNC:
                begin
                    if (timer_reg == SYNC_PULSE_CYC - 12'h001)
                    begin
                        state_reg <= ST_GAP;
                        timer_reg <= 12'h000;
                    end
                end
                ST_GAP:
                begin
                    zero_seen_reg <= 1'b0;
                    if (timer_reg == WIN_DELAY_CYC - 12'h001)
                    begin
                        state_reg <= ST_WIN; // [RQ8]
                        timer_reg <= 12'h000;
                    end
                end
                ST_WIN:
                begin
                    if (foreign_low)
                    begin
                        zero_seen_reg <= 1'b1;
                    end
                    if (timer_reg == WIN_LEN_CYC - 12'h001)
                    begin
                        rx_word_reg[bit_cnt_reg] <= rx_bit; // [RQ9] [RQ10]
                        state_reg <= ST_REST;
                        timer_reg <= 12'h000;
                    end
                end
                ST_REST:
                begin
                    if (timer_reg == REST_CYC - 12'h001)
                    begin
                        timer_reg <= 12'h000;
                        if (bit_cnt_reg == LAST_BIT)
                        begin
                            eq_reg <= word_equal; // [RQ11]
                            state_reg <= ST_EQ;
                        end
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1; // [RQ10]
                            state_reg <= ST_SYNC; // [RQ7]
                        end
                    end
                end
                ST_EQ:
                begin
                    if (timer_reg == EQ_WIN_CYC - 12'h001)
                    begin
                        state_reg <= ST_IDLE;
                        eq_reg <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_word <= CFG_WORD_DEFAULT;
            upper_bit_check_limit <= LIM_DEFAULT;
            limit_ticks <= 9'h000;
        end
        else if (clk_en)
        begin
            if (por_q)
            begin
                config_word <= CFG_WORD_DEFAULT; // [RQ2]
                upper_bit_check_limit <= LIM_DEFAULT; // [RQ1]
            end
            else if (commit && lim_target)
            begin
                if (rx_word_reg[5:0] >= LIM_LOWEST_VALID)
                begin
                    upper_bit_check_limit <= rx_word_reg[5:0]; // [RQ1]
                end
            end
            else if (commit)
            begin
                config_word <= rx_word_reg;
            end
            // Limit time in basic clocks: (limit - 1) times the extension factor.
            limit_ticks <= 9'({3'h0, upper_bit_check_limit - 6'h01} <<
                              (2'h3 - config_word[RANGE_MSB:RANGE_LSB])); // [RQ1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line drive, reset marker and status outputs.

    logic [15:0] marker_cnt_reg;
    logic marker_low_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reset_marker <= 1'b1;
            marker_cnt_reg <= 16'h0000;
            marker_low_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (por_q)
            begin
                reset_marker <= 1'b1; // [RQ4]
            end
            else if (go && start_long)
            begin
                reset_marker <= 1'b0; // [RQ17]
            end
            // Half period is long enough to stay below any data frequency.
            if (!reset_marker || marker_cnt_reg == 16'(MARKER_HALF - 1))
            begin
                marker_cnt_reg <= 16'h0000;
                marker_low_reg <= reset_marker && !marker_low_reg; // [RQ4] [RQ5]
            end
            else
            begin
                marker_cnt_reg <= marker_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_out <= 1'b0;
            data_oe <= 1'b0;
            rx_disable <= 1'b0;
            off_cmd <= 1'b0;
            por_active <= 1'b1;
        end
        else if (clk_en)
        begin
            data_out <= 1'b0;
            data_oe <= (state_reg == ST_IDLE && reset_marker && marker_low_reg) ||
                       state_reg == ST_SYNC || // [RQ7]
                       (state_reg == ST_EQ && eq_reg && timer_reg < ACK_PULSE_CYC); // [RQ11]
            rx_disable <= state_reg != ST_IDLE; // [RQ14]
            off_cmd <= state_reg == ST_WIN && timer_reg == WIN_LEN_CYC - 12'h001 &&
                       bit_cnt_reg == 4'(OFF_BIT) && rx_bit; // [RQ15]
            por_active <= por_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n || !clk_en);

    property p_lim_reject;
        (commit && lim_target && rx_word_reg[5:0] < LIM_LOWEST_VALID && !por_q)
            |=> $stable(upper_bit_check_limit);
    endproperty
    a_lim_reject: assert property (p_lim_reject) // [RQ1]
        else $error("Invalid limit code was stored.");

    property p_defaults;
        por_q |=> config_word == CFG_WORD_DEFAULT && upper_bit_check_limit == LIM_DEFAULT;
    endproperty
    a_defaults: assert property (p_defaults) // [RQ2]
        else $error("Defaults not loaded during reset.");

    property p_quiet_idle;
        (state_reg == ST_IDLE && !reset_marker) [*2] |-> !data_oe;
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) // [RQ4]
        else $error("Line driven while idle without marker.");

    property p_sync_drive;
        state_reg == ST_SYNC |=> data_oe;
    endproperty
    a_sync_drive: assert property (p_sync_drive) // [RQ7]
        else $error("Synchronization pulse missing.");

    property p_window_released;
        state_reg == ST_WIN |-> !data_oe;
    endproperty
    a_window_released: assert property (p_window_released) // [RQ8]
        else $error("Line driven inside programming window.");

    property p_bit_count;
        state_reg == ST_EQ |-> bit_cnt_reg == LAST_BIT;
    endproperty
    a_bit_count: assert property (p_bit_count) // [RQ10]
        else $error("Equivalence window before fourteenth bit.");

    property p_ack_only_equal;
        (state_reg == ST_EQ && data_oe) |-> eq_reg;
    endproperty
    a_ack_only_equal: assert property (p_ack_only_equal) // [RQ11]
        else $error("Acknowledge without equal word.");

    property p_rx_off;
        (state_reg != ST_IDLE) ##1 (state_reg != ST_IDLE) |-> rx_disable;
    endproperty
    a_rx_off: assert property (p_rx_off) // [RQ14]
        else $error("Receive path enabled during transfer.");

    property p_short_ignored;
        (state_reg == ST_IDLE && start_short && !start_long && reset_marker) |=>
            state_reg == ST_IDLE && reset_marker;
    endproperty
    a_short_ignored: assert property (p_short_ignored) // [RQ16]
        else $error("Short start pulse accepted during marker.");

    property p_long_starts;
        (state_reg == ST_IDLE && start_long && !por_q) |=>
            state_reg == ST_DELAY && !reset_marker;
    endproperty
    a_long_starts: assert property (p_long_starts) // [RQ17]
        else $error("Long start pulse not honoured.");

    property p_off_bit;
        off_cmd |-> $past(state_reg) == ST_WIN && rx_word_reg[OFF_BIT];
    endproperty
    a_off_bit: assert property (p_off_bit) // [RQ15]
        else $error("Off command without bit one set.");

    c_transfer: cover property (commit);
    c_ack: cover property (state_reg == ST_EQ && data_oe);
    c_marker_cancel: cover property ($fell(reset_marker));

endmodule : config_word_serial_programmer

// *** cfgprog_host.sv ***
// Host microcontroller model on the shared open-drain data line.
// Assumes a pull-up on the wire and that the device pulls it low while data_oe is high.
`timescale 1ns/1ps
module cfgprog_host
(
    input wire logic mclk,
    input wire logic data_oe,
    output logic data_in
);
    import cfgprog_pkg::*;
    logic host_pull = 1'b0;
    int bad_pulses = 0;
    int sync_seen = 0;
    int first_gap = 0;

    // The pull-up takes the wire high once both parties have released it.
    assign data_in = ~(data_oe | host_pull);

    task automatic wait_oe(input logic lvl, output int n);
        n = 0;
        while (data_oe !== lvl && n < 5000)
        begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_oe

    task automatic start_pulse(input int len);
        @(negedge mclk);
        host_pull = 1'b1;
        repeat (len) @(negedge mclk);
        host_pull = 1'b0;
    endtask : start_pulse

    task automatic send_word(input word_t w);
        int n;
        for (int i = 0; i < WORD_BITS; i++)
        begin
            wait_oe(1'b1, n);
            if (i == 0)
                first_gap = n;
            wait_oe(1'b0, n);
            sync_seen++;
            if (n != SYNC_PULSE_CYC)
                bad_pulses++;
            repeat (WIN_DELAY_CYC + 100) @(negedge mclk);
            if (!w[i])
            begin
                host_pull = 1'b1;
                repeat (100) @(negedge mclk);
                host_pull = 1'b0;
            end
        end
    endtask : send_word
endmodule : cfgprog_host

// *** config_word_serial_programmer_bench.sv ***
// Self-checking bench of the serial configuration programmer.
// Assumes the host model resolves the wire; start, marker and reset hold counts are shortened by parameters.
`timescale 1ns/1ps
module config_word_serial_programmer_bench;
    import cfgprog_pkg::*;
    localparam int unsigned LONG_MIN = 60;
    localparam int unsigned HALF = 200;
    localparam int unsigned HOLD = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b1;
    logic clk_en = 1'b1;
    logic data_out;
    logic data_in;
    logic data_oe;
    word_t config_word;
    lim_t upper_bit_check_limit;
    logic [8:0] limit_ticks;
    logic rx_disable;
    logic off_cmd;
    logic reset_marker;
    logic por_active;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    int offs = 0;

    initial forever #50 mclk = ~mclk;

    config_word_serial_programmer #(.START_LONG_MIN(LONG_MIN), .MARKER_HALF(HALF),
        .RESET_HOLD(HOLD)) config_word_serial_programmer_inst (.mclk(mclk), .rst_n(rst_n),
        .clk_en(clk_en), .supply_ok(supply_ok), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .config_word(config_word), .upper_bit_check_limit(upper_bit_check_limit),
        .limit_ticks(limit_ticks), .rx_disable(rx_disable), .off_cmd(off_cmd),
        .reset_marker(reset_marker), .por_active(por_active));

    cfgprog_host cfgprog_host_inst (.mclk(mclk), .data_oe(data_oe), .data_in(data_in));

    always @(negedge mclk)
        if (off_cmd === 1'b1)
            offs++;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge mclk);
        check("config_word", 16'(config_word), 16'h0000);
        check("limit", 16'(upper_bit_check_limit), 16'h0018);
        check("marker", 16'(reset_marker), 16'h0001);
        rst_n = 1'b1;
        repeat (HOLD - 1) @(negedge mclk);
        check("por early", 16'(por_active), 16'h0001);
        repeat (7) @(negedge mclk);
        check("por", 16'(por_active), 16'h0000);
        cfgprog_host_inst.wait_oe(1'b1, n);
        cfgprog_host_inst.wait_oe(1'b0, n);
        check("marker high", 16'(n), 16'(HALF));
        cfgprog_host_inst.wait_oe(1'b1, n);
        check("marker low", 16'(n), 16'(HALF));
        // A short start pulse in a marker gap must be ignored while the marker shows.
        cfgprog_host_inst.wait_oe(1'b0, n);
        cfgprog_host_inst.start_pulse(40);
        repeat (20) @(negedge mclk);
        check("short rx_disable", 16'(rx_disable), 16'h0000);
        check("short marker", 16'(reset_marker), 16'h0001);
        cfgprog_host_inst.start_pulse(LONG_MIN + 40);
        fork
            cfgprog_host_inst.send_word(14'h3018);
            begin
                repeat (100) @(negedge mclk);
                check("long marker", 16'(reset_marker), 16'h0000);
                check("rx_disable", 16'(rx_disable), 16'h0001);
                // Freezing the clock enable stretches the programming delay.
                clk_en = 1'b0;
                repeat (50) @(negedge mclk);
                clk_en = 1'b1;
            end
        join
        n = cfgprog_host_inst.first_gap;
        check("delay", 16'(n >= PROG_DELAY_CYC + 50 && n <= PROG_DELAY_CYC + 60), 16'h1);
        check("sync count", 16'(cfgprog_host_inst.sync_seen), 16'h000e);
        check("sync len", 16'(cfgprog_host_inst.bad_pulses), 16'h0000);
        cfgprog_host_inst.wait_oe(1'b1, n);
        check("data_out", 16'(data_out), 16'h0000);
        cfgprog_host_inst.wait_oe(1'b0, n);
        check("ack len", 16'(n), 16'(ACK_PULSE_CYC));
        repeat (EQ_WIN_CYC) @(negedge mclk);
        check("rx end", 16'(rx_disable), 16'h0000);
        check("config_word", 16'(config_word), 16'h0000);
        check("limit", 16'(upper_bit_check_limit), 16'h0018);
        check("ticks", 16'(limit_ticks), 16'h00b8);
        check("off", 16'(offs), 16'h0000);
        supply_ok = 1'b0;
        repeat (5) @(negedge mclk);
        check("brown por", 16'(por_active), 16'h0001);
        check("brown marker", 16'(reset_marker), 16'h0001);
        supply_ok = 1'b1;
        repeat (HOLD + 6) @(negedge mclk);
        check("por again", 16'(por_active), 16'h0000);
        final_report();
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        fail_count++;
        final_report();
    end
endmodule : config_word_serial_programmer_bench
